/* pkg/fdc_status_pkg.sv */
// Package holding the register map, status field layout and command codes
// Assumes a 32-bit APB master; only the low byte of each register is used
package fdc_status_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_STATUS = 8'h00;   // Read-only status
    localparam logic [7:0] OFF_COMMAND = 8'h04;  // Write-only command
    localparam logic [7:0] OFF_DATA = 8'h08;     // Data holding register
    // ----------------------------------------
    // Status bit positions
    // ----------------------------------------
    localparam int BIT_MOTOR = 7;
    localparam int BIT_WPROT = 6;
    localparam int BIT_BUSY = 0;
    localparam int BIT_OVERRUN = 2;
    localparam int BIT_REQUEST = 1;
    // ----------------------------------------
    // Command codes (upper nibble)
    // ----------------------------------------
    localparam logic [3:0] CMD_FORCE = 4'hd;     // Forced interrupt
    localparam logic [3:0] CMD_RDADDR = 4'hc;    // Read address
    localparam logic [3:0] CMD_RDTRK = 4'he;     // Read track
    localparam logic [3:0] CMD_WRTRK = 4'hf;     // Write track
    localparam logic [2:0] CMD_WRSEC = 3'h5;     // Write sector, top three bits
    localparam logic [7:0] FILL_BYTE = 8'h00;    // Substituted on overrun
    localparam logic [23:0] PAD_ZERO = 24'h000000;
    // ----------------------------------------
    // Status personality
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        MODE_TYPE1 = 2'b00,   // Positioning or idle view
        MODE_XFER = 2'b01,    // Sector or track transfer view
        MODE_FROZEN = 2'b10   // Stopped by forced interrupt while busy
    } mode_e;
endpackage : fdc_status_pkg

/* hw/fdc_status_and_format.sv */
// Status register and format byte handshake of the disk controller
// Assumes a command engine beside it that reports events as one-cycle
// pulses and asks for each disk byte with byte_slot; all inputs synchronous
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps

// Overview of operation
// - Bit 7 always mirrors motor output
// - Bit 6 shows write protect on writes
// - Type I bit 5 means spin-up done
// - Transfer bit 5 flags deleted data mark
// - Type I bit 4 flags seek error
// - Transfer bit 4 flags record not found
// - Bit 3 flags CRC error
// - Transfer bit 2 flags lost byte
// - Type I/idle bit 2 shows track zero
// - Transfer bit 1 equals data request
// - Type I/idle bit 1 shows index
// - Bit 0 is busy
// - Forced interrupt while busy freezes bits 6-1
// - Write protect stays live after reset, Type I or an idle forced interrupt only
// - Read address without IDs sets record-missing
// - One data request per written byte
// - Write track ends at next index
// - New command sets busy, clears status
// - Data register access clears data request
module fdc_status_and_format
#(
    parameter int ADDR_W = 8  // APB address width
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic motor_on_in,
    input wire logic write_protect_in,
    input wire logic outer_track_input,
    input wire logic index_input,
    input wire logic spinup_evt,
    input wire logic verify_fail_evt,
    input wire logic deleted_mark_evt,
    input wire logic record_missing_evt,
    input wire logic crc_error_evt,
    input wire logic cmd_done,
    input wire logic byte_slot,
    input wire logic [7:0] rd_byte,
    output logic data_request,
    output logic busy_flag,
    output logic [7:0] cmd_code,
    output logic cmd_strobe,
    output logic [7:0] wr_byte,
    output logic wr_byte_valid
);
    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    if (ADDR_W < 8)
    begin : g_bad_addr
        $error("ADDR_W must be at least 8");
    end

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire logic [7:0] addr_lo = paddr[7:0];
    wire logic upper_zero = (paddr >> 8) == '0;
    wire logic hit_status = upper_zero && (addr_lo == fdc_status_pkg::OFF_STATUS);
    wire logic hit_cmd = upper_zero && (addr_lo == fdc_status_pkg::OFF_COMMAND);
    wire logic hit_data = upper_zero && (addr_lo == fdc_status_pkg::OFF_DATA);
    wire logic hit_any = hit_status || hit_cmd || hit_data;
    wire logic apb_access = psel && penable && !pready;  // Answer prepared here
    wire logic apb_done = psel && penable && pready;     // Effects land here
    wire logic wr_cmd = apb_done && pwrite && hit_cmd;
    wire logic wr_data = apb_done && pwrite && hit_data;
    wire logic rd_data = apb_done && !pwrite && hit_data;
    wire logic wr_status = apb_done && pwrite && hit_status;

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    wire logic [3:0] cmd_hi = pwdata[7:4];
    wire logic is_force = cmd_hi == fdc_status_pkg::CMD_FORCE;
    wire logic is_type1 = !pwdata[7];
    wire logic is_wrtrk = cmd_hi == fdc_status_pkg::CMD_WRTRK;
    wire logic is_writing = is_wrtrk || (cmd_hi[3:1] == fdc_status_pkg::CMD_WRSEC);
    wire logic new_cmd = wr_cmd && !is_force;
    wire logic force_busy = wr_cmd && is_force && busy_flag;
    wire logic force_idle = wr_cmd && is_force && !busy_flag;
    wire logic status_clear = new_cmd || force_idle;

    // ----------------------------------------
    // State
    // ----------------------------------------
    fdc_status_pkg::mode_e mode;      // Which bit meanings apply
    fdc_status_pkg::mode_e next_mode;
    logic write_op;                   // Current command writes the disk
    logic addr_op;                    // Read address command
    logic track_op;                   // Read or write track command
    logic wp_live;                    // Write protect tracked while idle
    logic s5_flag;                    // Spin-up or record type
    logic s4_flag;                    // Seek error or record missing
    logic crc_flag;                   // CRC error
    logic overrun_flag;               // Host too slow
    logic [7:0] data_reg;             // Data holding register
    logic [6:1] held_bits;            // Snapshot for the frozen view

    wire logic in_xfer = mode == fdc_status_pkg::MODE_XFER;
    wire logic frozen = mode == fdc_status_pkg::MODE_FROZEN;
    wire logic xfer_busy = busy_flag && in_xfer;
    wire logic slot_write = byte_slot && xfer_busy && write_op;
    wire logic slot_read = byte_slot && xfer_busy && !write_op;

    // ----------------------------------------
    // Live status composition
    // ----------------------------------------
    // write protect view
    wire logic s6_xfer = write_op && write_protect_in;
    wire logic s6_t1 = wp_live && !busy_flag && write_protect_in;
    // bit 5 meaning, zero where undefined
    wire logic s5_live = s5_flag && !(in_xfer && (addr_op || track_op));
    // error bits, zero for track commands
    wire logic s4_live = s4_flag && !(in_xfer && track_op);
    wire logic s3_live = crc_flag && !(in_xfer && track_op);
    // bits 2 and 1 switch with the command type
    wire logic s2_live = in_xfer ? overrun_flag : outer_track_input;
    wire logic s1_live = in_xfer ? data_request : index_input;
    wire logic s6_live = in_xfer ? s6_xfer : s6_t1;
    wire logic [6:1] live_bits = {s6_live, s5_live, s4_live, s3_live, s2_live, s1_live};
    // motor and busy always live, the rest may be frozen
    wire logic [7:0] status_now = {motor_on_in, frozen ? held_bits : live_bits, busy_flag};

    // ----------------------------------------
    // Next values for sticky flags
    // ----------------------------------------
    // Event wins over a same-cycle clear, so no error is lost
    wire logic next_s5 = ((spinup_evt || deleted_mark_evt) && busy_flag)
        || (s5_flag && !status_clear);
    // a read address on a blank track reports record missing
    wire logic next_s4 = ((verify_fail_evt || record_missing_evt) && busy_flag)
        || (s4_flag && !status_clear);
    wire logic next_crc = (crc_error_evt && busy_flag) || (crc_flag && !status_clear);
    wire logic next_overrun = (byte_slot && xfer_busy && data_request)
        || (overrun_flag && !status_clear);
    // request raised per byte; host access or end drops it
    wire logic drq_set = slot_write || slot_read || (new_cmd && is_writing && !is_type1);
    wire logic drq_clr = wr_data || rd_data || status_clear || cmd_done || force_busy;
    wire logic next_drq = drq_set || (data_request && !drq_clr);

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    always_comb
    begin
        next_mode = mode;
        if (new_cmd)
        begin
            next_mode = is_type1 ? fdc_status_pkg::MODE_TYPE1 : fdc_status_pkg::MODE_XFER;
        end
        else if (force_busy)
        begin
            next_mode = fdc_status_pkg::MODE_FROZEN;
        end
        else if (force_idle)
        begin
            next_mode = fdc_status_pkg::MODE_TYPE1;  // Idle force shows Type I view
        end
    end

    // ----------------------------------------
    // Command tracking and busy
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode <= fdc_status_pkg::MODE_TYPE1;
            busy_flag <= 1'b0;
            write_op <= 1'b0;
            addr_op <= 1'b0;
            track_op <= 1'b0;
            wp_live <= 1'b1;
        end
        else
        begin
            mode <= next_mode;
            // new command sets busy; force or end clears it
            // write track ends on the engine's index-time done
            if (new_cmd)
                busy_flag <= 1'b1;
            else if (wr_cmd || cmd_done)
                busy_flag <= 1'b0;
            if (new_cmd)
            begin
                write_op <= is_writing && !is_type1;
                addr_op <= cmd_hi == fdc_status_pkg::CMD_RDADDR;
                track_op <= is_wrtrk || (cmd_hi == fdc_status_pkg::CMD_RDTRK);
                wp_live <= is_type1;
            end
            else if (force_idle)
            begin
                wp_live <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Sticky status flags and snapshot
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s5_flag <= 1'b0;
            s4_flag <= 1'b0;
            crc_flag <= 1'b0;
            overrun_flag <= 1'b0;
            held_bits <= '0;
        end
        else
        begin
            s5_flag <= next_s5;
            s4_flag <= next_s4;
            crc_flag <= next_crc;
            overrun_flag <= next_overrun;
            if (!frozen)
                held_bits <= live_bits;
        end
    end

    // ----------------------------------------
    // Data holding register and disk byte handoff
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_reg <= fdc_status_pkg::FILL_BYTE;
            data_request <= 1'b0;
            wr_byte <= fdc_status_pkg::FILL_BYTE;
            wr_byte_valid <= 1'b0;
        end
        else
        begin
            data_request <= next_drq;
            wr_byte_valid <= slot_write;
            if (slot_read)
                data_reg <= rd_byte;
            else if (wr_data)
                data_reg <= pwdata[7:0];
            // unserviced request puts a zero byte on the disk
            if (slot_write)
                wr_byte <= data_request ? fdc_status_pkg::FILL_BYTE : data_reg;
        end
    end

    // ----------------------------------------
    // Command strobe to the engine
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_code <= fdc_status_pkg::FILL_BYTE;
            cmd_strobe <= 1'b0;
        end
        else
        begin
            cmd_strobe <= wr_cmd;
            if (wr_cmd)
                cmd_code <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // APB answer, one wait state
    // ----------------------------------------
    // status writes are accepted but change nothing
    wire logic [7:0] read_byte = hit_status ? status_now : (hit_data ? data_reg : 8'h00);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= apb_access;
            pslverr <= apb_access && !hit_any;
            if (apb_access && !pwrite)
                prdata <= {fdc_status_pkg::PAD_ZERO, read_byte};
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_motor_mirror: assert property (
        @(posedge pclk) disable iff (!presetn)
        apb_access && !pwrite && hit_status |=> prdata[7] == $past(motor_on_in))
        else $error("Status bit 7 does not follow motor");
    a_busy_on_cmd: assert property (
        @(posedge pclk) disable iff (!presetn)
        new_cmd |=> busy_flag && !overrun_flag || busy_flag && byte_slot)
        else $error("Busy not set by new command");
    a_force_freeze: assert property (
        @(posedge pclk) disable iff (!presetn)
        force_busy |=> !busy_flag && status_now[6:1] == $past(status_now[6:1]))
        else $error("Forced interrupt disturbed status");
    a_drq_access: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_data && !byte_slot && !new_cmd |=> !data_request)
        else $error("Data access did not clear request");
    a_byte_request: assert property (
        @(posedge pclk) disable iff (!presetn)
        slot_write |=> data_request && wr_byte_valid ##1 !wr_byte_valid || byte_slot)
        else $error("Written byte without new request");
    a_lost_byte: assert property (
        @(posedge pclk) disable iff (!presetn)
        byte_slot && xfer_busy && data_request && !wr_cmd |=> status_now[2])
        else $error("Lost byte not reported");
    a_track_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        !busy_flag && mode == fdc_status_pkg::MODE_TYPE1
        |-> status_now[2] == outer_track_input && status_now[1] == index_input)
        else $error("Idle view not live");
    a_status_ro: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_status && !busy_flag |=> {s5_flag, s4_flag, crc_flag} == $past({s5_flag, s4_flag, crc_flag}))
        else $error("Status write changed status");
    a_track_end: assert property (
        @(posedge pclk) disable iff (!presetn)
        cmd_done && !wr_cmd |=> !busy_flag && !data_request)
        else $error("Command did not end on done");
endmodule : fdc_status_and_format

/* verification/fdc_engine_model.sv */
// Behavioural command engine and drive model beside the status block
// Assumes one clock; the block reports commands via cmd_code and cmd_strobe
`timescale 1ns/100ps
module fdc_engine_model
#(
    parameter int SLOT_GAP = 24,  // Cycles between disk byte slots
    parameter int NSLOT = 230,    // Slots before the closing index
    parameter int DONE_DLY = 20   // Run time of a read address
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic busy_flag,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_strobe,
    output logic byte_slot,
    output logic cmd_done,
    output logic [7:0] rd_byte,
    output logic [15:0] slot_count
);
    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    logic [15:0] gap_cnt;  // Cycles since the last slot
    wire wr_cmd = (cmd_code[7:5] == fdc_status_pkg::CMD_WRSEC)
        || (cmd_code[7:4] == fdc_status_pkg::CMD_WRTRK);
    wire rd_addr = cmd_code[7:4] == fdc_status_pkg::CMD_RDADDR;
    // Disk pace: slots never wait for a slow host, as on a real spindle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            byte_slot <= 1'b0;
            cmd_done <= 1'b0;
            rd_byte <= 8'h00;
            slot_count <= 16'h0000;
            gap_cnt <= 16'h0000;
        end
        else
        begin
            byte_slot <= 1'b0;
            cmd_done <= 1'b0;
            // Read byte lines never rest on a stale value
            rd_byte <= rd_byte + 8'h3b;
            if (cmd_strobe)
            begin
                gap_cnt <= 16'h0000;
                slot_count <= 16'h0000;
            end
            else if (busy_flag && !cmd_done)
            begin
                gap_cnt <= gap_cnt + 16'h0001;
                if (wr_cmd && gap_cnt == 16'(SLOT_GAP - 1))
                begin
                    gap_cnt <= 16'h0000;
                    if (slot_count == 16'(NSLOT))
                        cmd_done <= 1'b1;
                    else
                    begin
                        byte_slot <= 1'b1;
                        slot_count <= slot_count + 16'h0001;
                    end
                end
                // Blank track: read address gives up after a while
                if (rd_addr && gap_cnt == 16'(DONE_DLY))
                    cmd_done <= 1'b1;
            end
        end
    end
endmodule : fdc_engine_model

/* verification/testbench.sv */
// Self-checking bench: APB host tasks plus the engine model
// Assumes the status block and package as delivered; one 40 MHz clock
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    localparam int NSLOT = 700;  // Slots per track, enough for either layout and its run-out
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, motor, wp, t0, idx, trk_on, prev_req, er, dd;
    logic [7:0] paddr, cmd_code, wr_byte, rd_byte;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] evts;  // Engine event pulses
    logic [15:0] slot_count;
    logic pready, pslverr, byte_slot, cmd_done, data_request, busy_flag, cmd_strobe;
    logic wr_byte_valid;
    int err_count = 0, num_checks = 0, cyc = 0, k = 0, wr_n = 0, req_n = 0, n;
    always #12.5 pclk = ~pclk;
    fdc_status_and_format #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .motor_on_in(motor),
        .write_protect_in(wp), .outer_track_input(t0), .index_input(idx),
        .spinup_evt(evts[0]), .verify_fail_evt(evts[1]), .deleted_mark_evt(evts[2]),
        .record_missing_evt(evts[3]), .crc_error_evt(evts[4]), .cmd_done(cmd_done),
        .byte_slot(byte_slot), .rd_byte(rd_byte), .data_request(data_request),
        .busy_flag(busy_flag), .cmd_code(cmd_code), .cmd_strobe(cmd_strobe),
        .wr_byte(wr_byte), .wr_byte_valid(wr_byte_valid));
    fdc_engine_model #(.SLOT_GAP(24), .NSLOT(NSLOT), .DONE_DLY(20)) engine (.pclk(pclk),
        .presetn(presetn), .busy_flag(busy_flag), .cmd_code(cmd_code),
        .cmd_strobe(cmd_strobe), .byte_slot(byte_slot), .cmd_done(cmd_done),
        .rd_byte(rd_byte), .slot_count(slot_count));
    // ----------------------------------------
    // Host side helpers
    // ----------------------------------------
    // single density and double density track layouts, then fill
    function automatic logic [7:0] fmt_byte(input logic dd_sel, input int i);
        if (dd_sel)
        begin
            if (i < 60) return 8'h4e;
            if (i < 72) return 8'h00;
            if (i < 75) return 8'hf5;
            if (i == 75) return 8'hfe;
            if (i == 76) return 8'h05;  // Track
            if (i == 78 || i == 79) return 8'h01;  // Sector and length code
            if (i < 80) return 8'h00;   // Side
            if (i == 80) return 8'hf7;
            if (i < 103) return 8'h4e;
            if (i < 115) return 8'h00;
            if (i < 118) return 8'hf5;
            if (i == 118) return 8'hfb;
            if (i < 631) return 8'he5;
            if (i == 631) return 8'hf7;
            return 8'h4e;               // Post data gap and run-out
        end
        if (i < 40) return 8'hff;
        if (i < 46) return 8'h00;
        if (i == 46) return 8'hfe;
        if (i == 47) return 8'h05;  // Track
        if (i == 49) return 8'h01;  // Sector
        if (i < 51) return 8'h00;   // Side and length code
        if (i == 51) return 8'hf7;
        if (i < 63) return 8'hff;
        if (i < 69) return 8'h00;
        if (i == 69) return 8'hfb;
        if (i < 198) return 8'he5;
        if (i == 198) return 8'hf7;
        return 8'hff;
    endfunction : fmt_byte
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int w;
        w = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            w++;
        end
        while (pready !== 1'b1 && w < 64);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, {24'h000000, e})
    endtask : rd_chk
    task automatic evt(input int b);
        evts[b] <= 1'b1;
        @(posedge pclk);
        evts[b] <= 1'b0;
        @(posedge pclk);
    endtask : evt
    // Format one track: one byte per request until the index ends it
    task automatic fmt_track(input logic d);
        int j;
        j = 0;
        dd <= d;
        trk_on <= 1'b1;
        apb(1'b1, fdc_status_pkg::OFF_COMMAND, 32'hf0);
        @(posedge pclk);
        for (n = 0; n < 20000 && busy_flag === 1'b1; n++)
        begin
            if (data_request === 1'b1)
            begin
                apb(1'b1, fdc_status_pkg::OFF_DATA, {24'h000000, fmt_byte(d, j)});
                j++;
            end
            else
                @(posedge pclk);
        end
        trk_on <= 1'b0;
        k += j;
        `CHK(j, NSLOT + 1)
        apb(1'b0, fdc_status_pkg::OFF_STATUS, 32'h0);
        `CHK({rd[2], rd[0]}, 2'b00)
    endtask : fmt_track
    task complete_run;
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    // Write track monitor, request counter and hang guard
    always @(posedge pclk)
    begin
        if (trk_on && wr_byte_valid === 1'b1)
        begin
            `CHK(wr_byte, fmt_byte(dd, dd ? wr_n - NSLOT : wr_n))
            wr_n++;
        end
        if (trk_on && data_request === 1'b1 && prev_req !== 1'b1)
            req_n++;
        prev_req = data_request;
        cyc++;
        if (cyc > 40000)
        begin
            err_count++;
            complete_run();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, evts, trk_on, dd, presetn} = '0;
        {motor, wp, t0, idx} = 4'hf;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(fdc_status_pkg::OFF_STATUS, 8'hc6);
        apb(1'b1, fdc_status_pkg::OFF_STATUS, 32'h000000ff);
        rd_chk(fdc_status_pkg::OFF_STATUS, 8'hc6);
        apb(1'b0, 8'h0c, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        // Positioning command: spin-up then failed verify
        apb(1'b1, fdc_status_pkg::OFF_COMMAND, 32'h10);
        evt(0);
        evt(1);
        rd_chk(fdc_status_pkg::OFF_STATUS, 8'hb7);
        apb(1'b1, fdc_status_pkg::OFF_COMMAND, 32'hd0);
        // Index moves after the freeze; the frozen view must not follow it
        idx <= 1'b0;
        rd_chk(fdc_status_pkg::OFF_STATUS, 8'hb6);
        apb(1'b1, fdc_status_pkg::OFF_COMMAND, 32'hd0);
        rd_chk(fdc_status_pkg::OFF_STATUS, 8'hc4);
        // Write sector that the host leaves unserviced for two slots
        apb(1'b1, fdc_status_pkg::OFF_COMMAND, 32'ha0);
        evt(2);
        evt(3);
        for (n = 0; n < 200 && slot_count < 16'd2; n++) @(posedge pclk);
        rd_chk(fdc_status_pkg::OFF_STATUS, 8'hf7);
        apb(1'b1, fdc_status_pkg::OFF_DATA, 32'h5a);
        `CHK(data_request, 1'b0)
        rd_chk(fdc_status_pkg::OFF_DATA, 8'h5a);
        apb(1'b1, fdc_status_pkg::OFF_COMMAND, 32'hd0);
        rd_chk(fdc_status_pkg::OFF_STATUS, 8'hf4);
        // Read address on a track with no ID fields
        t0 <= 1'b0;
        apb(1'b1, fdc_status_pkg::OFF_COMMAND, 32'hc0);
        evt(3);
        evt(4);
        for (n = 0; n < 200 && busy_flag !== 1'b0; n++) @(posedge pclk);
        rd_chk(fdc_status_pkg::OFF_STATUS, 8'h98);
        // Format a single density track, then a double density one
        fmt_track(1'b0);
        fmt_track(1'b1);
        `CHK(wr_n, 2 * NSLOT)
        `CHK(req_n, k)
        complete_run();
    end
endmodule : testbench
